// >>> bml_boot_mode_loader.sv
// Purpose: Reset-time boot sequencer loading blocks into instruction memory.
// Assumes: Memory port and core run on ref_clk_i; host link on its own clock.
// Notes:   Flash is read one byte per access on the low lane.
//
// Behaviour
// [R01] Mode 00 runs external memory at 0x2000_0000
// [R02] Modes 00/01 use slowest async bus timing
// [R03] Mode 01 loads from flash on bank 0
// [R04] Bank-0 select doubles as on-chip flash enable
// [R05] Mode 10 receives image as serial slave
// [R06] Hold flag stops host while loader busy
// [R07] Hold flag number from header flag bits 10:5
// [R08] Mode 11 masters serial memory with select
// [R09] Read command, zero address bytes until detected
// [R10] Mode pins sampled on every reset
// [R11] Every block starts with a ten-byte header
// [R12] Any block count, then run L1 start
// [R13] Bit 4 skips boot on software reset
// [R14] Non-bypass modes start at 0xFFA0_0000
// [R15] Sampled mode holds until next reset
`default_nettype none

module bml_boot_mode_loader (
   input  wire logic        ref_clk_i,
   input  wire logic        nrst_i,
   input  wire logic        sw_reset_i,
   input  wire logic        skip_boot_i,
   input  wire logic [1:0]  boot_select_pins_i,
   output logic      [4:0]  rst_cfg_o,
   output logic             boot_done_o,
   output logic             boot_fail_o,
   output logic      [31:0] start_pc_o,
   output logic             ext_pack16_o,
   output logic      [3:0]  amc_hold_o,
   output logic      [3:0]  amc_access_o,
   output logic      [3:0]  amc_setup_o,
   output logic             async_bank0_select_n_o,
   output logic             mem_rd_o,
   output logic      [31:0] mem_addr_o,
   input  wire logic [7:0]  mem_data_i,
   input  wire logic        mem_ack_i,
   output logic             l1_we_o,
   output logic      [31:0] l1_addr_o,
   output logic      [7:0]  l1_data_o,
   output logic             serial_memory_select_out_n_o,
   output logic             spi_sck_o,
   output logic             spi_mosi_o,
   input  wire logic        spi_miso_i,
   input  wire logic        link_sck_i,
   input  wire logic        link_ss_n_i,
   input  wire logic        link_mosi_i,
   output logic             host_hold_flag_o,
   output logic      [5:0]  host_hold_sel_o
);

   typedef enum logic [2:0] {
      ST_SAMPLE, ST_DECIDE, ST_CMD, ST_ADDR, ST_HDR, ST_DATA, ST_RUN, ST_FAIL
   } bml_state_t;

   // Picks where the sequencer goes when a block is finished.
   function automatic bml_state_t bml_blk_end(input logic final_blk);
      bml_blk_end = final_blk ? ST_RUN : ST_HDR;
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   bml_state_t  st_q;
   logic        por_q, busy_q, rx_pend_q, final_q;
   logic [1:0]  smp_q, naddr_q, pin1_q, pin2_q;
   logic        miso1_q, miso2_q, tg1_q, tg2_q, tg3_q;
   logic [7:0]  slv_byte_q;
   logic [3:0]  hdr_cnt_q;
   logic [79:0] hdr_q;
   logic [31:0] dst_q, cnt_q, src_q;
   logic        sm_on_q;
   logic [2:0]  sm_div_q, sm_bit_q;
   logic [7:0]  sm_sh_q, sm_rx_q;
   logic [4:0]  cfg_q;
   localparam logic [2:0] HALF_CYC_M1 = bml_pkg::HALF_CYC - 3'h1;

   bml_rx_if rx_if ();

   bml_spi_rx u_rx (
      .link_sck_i  (link_sck_i),
      .link_nrst_i (nrst_i),
      .link_ss_n_i (link_ss_n_i),
      .link_mosi_i (link_mosi_i),
      .rx          (rx_if.rx)
   );

   // ----------------------------------------------------------------
   // Decoding and byte source selection
   // ----------------------------------------------------------------
   wire [1:0]  mode_w    = cfg_q[1:0];
   wire        need_w    = (st_q == ST_CMD) || (st_q == ST_ADDR) ||
                           (st_q == ST_HDR) || (st_q == ST_DATA);
   wire        go_w      = need_w && !busy_q;
   wire        sm_tick_w = sm_on_q && (sm_div_q == HALF_CYC_M1);
   wire        sm_done_w = sm_tick_w && spi_sck_o && (sm_bit_q == 3'h7);
   wire        tg_edge_w = tg2_q ^ tg3_q;
   wire [7:0]  tx_w      = (st_q == ST_CMD) ? bml_pkg::SPI_RD_CMD : bml_pkg::SPI_ADDR;
   wire        done_w    = (mode_w == bml_pkg::MODE_FLASH) ? (mem_rd_o && mem_ack_i) :
                           (mode_w == bml_pkg::MODE_SPI_M) ? sm_done_w :
                           (busy_q && rx_pend_q);
   wire [7:0]  bval_w    = (mode_w == bml_pkg::MODE_FLASH) ? mem_data_i :
                           (mode_w == bml_pkg::MODE_SPI_M) ? sm_rx_q : slv_byte_q;
   wire [79:0] hdr_nx_w  = {bval_w, hdr_q[79:8]};
   wire [15:0] flag_w    = hdr_nx_w[79:64];
   wire        skip_w    = !por_q && cfg_q[bml_pkg::CFG_NOBOOT];
   wire        hold_w    = (mode_w == bml_pkg::MODE_SPI_S) && (st_q != ST_RUN) &&
                           (st_q != ST_FAIL) && !(busy_q && !done_w);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // Straps and serial data in each pass two flops; the host byte toggle passes three.
   always_ff @(posedge ref_clk_i) begin
      pin1_q  <= boot_select_pins_i;
      pin2_q  <= pin1_q;
      miso1_q <= spi_miso_i;
      miso2_q <= miso1_q;
      tg1_q   <= rx_if.rx_tgl;
      tg2_q   <= tg1_q;
      tg3_q   <= tg2_q;
   end

   // Catch each host byte; a new byte wins over a same-cycle consume.
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         rx_pend_q  <= 1'b0;
         slv_byte_q <= 8'h00;
      end else if (tg_edge_w) begin
         rx_pend_q  <= 1'b1; // R05
         slv_byte_q <= rx_if.rx_byte;
      end else if (busy_q && rx_pend_q) begin
         rx_pend_q  <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Serial master engine
   // ----------------------------------------------------------------
   // Clock idles low, data changes on falling edges, sampled on rising.
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i || sw_reset_i) begin
         sm_on_q    <= 1'b0;
         sm_div_q   <= 3'h0;
         sm_bit_q   <= 3'h0;
         sm_sh_q    <= 8'h00;
         sm_rx_q    <= 8'h00;
         spi_sck_o  <= 1'b0;
         spi_mosi_o <= 1'b0;
      end else if (go_w && mode_w == bml_pkg::MODE_SPI_M) begin
         sm_on_q    <= 1'b1;
         sm_div_q   <= 3'h0;
         sm_bit_q   <= 3'h0;
         sm_sh_q    <= tx_w; // R09
         spi_mosi_o <= tx_w[7];
      end else if (sm_tick_w) begin
         sm_div_q  <= 3'h0;
         spi_sck_o <= ~spi_sck_o;
         if (!spi_sck_o) begin
            sm_rx_q <= {sm_rx_q[6:0], miso2_q};
         end else begin
            sm_bit_q   <= sm_bit_q + 3'h1;
            sm_sh_q    <= {sm_sh_q[6:0], 1'b0};
            spi_mosi_o <= sm_sh_q[6];
            sm_on_q    <= (sm_bit_q != 3'h7);
         end
      end else if (sm_on_q) begin
         sm_div_q <= sm_div_q + 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // Boot sequencer
   // ----------------------------------------------------------------
   // Samples straps, picks a source and walks headers and data blocks.
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i || sw_reset_i) begin
         st_q     <= ST_SAMPLE;
         por_q    <= !nrst_i;
         smp_q    <= 2'h0;
         busy_q   <= 1'b0;
         l1_we_o  <= 1'b0;
         mem_rd_o <= 1'b0;
         boot_done_o  <= 1'b0;
         boot_fail_o  <= 1'b0;
         ext_pack16_o <= 1'b0;
         async_bank0_select_n_o       <= 1'b1;
         serial_memory_select_out_n_o <= 1'b1;
         if (!nrst_i) begin
            cfg_q        <= bml_pkg::CFG_RST;
            start_pc_o   <= bml_pkg::L1_BASE;
            host_hold_sel_o <= 6'h00;
            amc_hold_o   <= bml_pkg::AMC_HOLD;
            amc_access_o <= bml_pkg::AMC_ACCESS;
            amc_setup_o  <= bml_pkg::AMC_SETUP;
            l1_addr_o    <= bml_pkg::L1_BASE;
            l1_data_o    <= 8'h00;
            mem_addr_o   <= bml_pkg::BANK0_BASE;
            hdr_q    <= 80'h0;
            hdr_cnt_q <= 4'h0;
            dst_q    <= 32'h0;
            cnt_q    <= 32'h0;
            src_q    <= 32'h0;
            naddr_q  <= 2'h0;
            final_q  <= 1'b0;
         end
      end else begin
         cfg_q[bml_pkg::CFG_NOBOOT] <= skip_boot_i; // R15
         l1_we_o <= 1'b0;
         if (go_w) begin
            busy_q <= 1'b1;
         end else if (done_w) begin
            busy_q <= 1'b0;
         end
         // Parallel flash reads go out on bank 0.
         if (go_w && mode_w == bml_pkg::MODE_FLASH) begin
            mem_rd_o   <= 1'b1; // R03
            mem_addr_o <= bml_pkg::BANK0_BASE + src_q;
            src_q      <= src_q + 32'h1;
            async_bank0_select_n_o <= 1'b0; // R04
         end else if (mem_rd_o && mem_ack_i) begin
            mem_rd_o <= 1'b0;
            async_bank0_select_n_o <= 1'b1;
         end
         case (st_q)
            ST_SAMPLE: begin
               smp_q <= smp_q + 2'h1;
               if (smp_q == bml_pkg::SMP_WAIT) begin
                  cfg_q[1:0]   <= pin2_q; // R10
                  amc_hold_o   <= bml_pkg::AMC_HOLD; // R02
                  amc_access_o <= bml_pkg::AMC_ACCESS;
                  amc_setup_o  <= bml_pkg::AMC_SETUP;
                  st_q         <= ST_DECIDE;
               end
            end
            ST_DECIDE: begin
               hdr_cnt_q <= 4'h0;
               naddr_q   <= 2'h0;
               src_q     <= 32'h0;
               if (skip_w) begin
                  start_pc_o  <= bml_pkg::L1_BASE; // R13
                  st_q        <= ST_RUN;
               end else if (mode_w == bml_pkg::MODE_BYPASS) begin
                  start_pc_o   <= bml_pkg::BYPASS_PC; // R01
                  ext_pack16_o <= 1'b1;
                  st_q         <= ST_RUN;
               end else if (mode_w == bml_pkg::MODE_SPI_M) begin
                  serial_memory_select_out_n_o <= 1'b0; // R08
                  st_q <= ST_CMD;
               end else begin
                  st_q <= ST_HDR;
               end
            end
            ST_CMD: if (done_w) begin
               st_q <= ST_ADDR;
            end
            ST_ADDR: if (done_w) begin
               naddr_q <= naddr_q + 2'h1;
               if (naddr_q != 2'h0 && bval_w != bml_pkg::SPI_BLANK) begin
                  hdr_q     <= hdr_nx_w; // R09
                  hdr_cnt_q <= 4'h1;
                  st_q      <= ST_HDR;
               end else if (naddr_q == bml_pkg::SPI_MAXA) begin
                  st_q <= ST_FAIL;
               end
            end
            ST_HDR: if (done_w) begin
               hdr_q     <= hdr_nx_w;
               hdr_cnt_q <= hdr_cnt_q + 4'h1;
               if (hdr_cnt_q == bml_pkg::HDR_LAST) begin
                  hdr_cnt_q <= 4'h0; // R11
                  dst_q     <= hdr_nx_w[31:0];
                  cnt_q     <= hdr_nx_w[63:32];
                  final_q   <= flag_w[bml_pkg::FLAG_FINAL];
                  host_hold_sel_o <= flag_w[bml_pkg::HOLD_MSB:bml_pkg::HOLD_LSB]; // R07
                  if (hdr_nx_w[63:32] == 32'h0) begin
                     st_q <= bml_blk_end(flag_w[bml_pkg::FLAG_FINAL]); // R12
                  end else begin
                     st_q <= ST_DATA;
                  end
               end
            end
            ST_DATA: if (done_w) begin
               l1_we_o   <= 1'b1;
               l1_addr_o <= dst_q;
               l1_data_o <= bval_w;
               dst_q     <= dst_q + 32'h1;
               cnt_q     <= cnt_q - 32'h1;
               if (cnt_q == 32'h1) begin
                  st_q <= bml_blk_end(final_q); // R12
               end
            end
            ST_RUN: begin
               boot_done_o <= 1'b1;
               serial_memory_select_out_n_o <= 1'b1;
               if (!ext_pack16_o) begin
                  start_pc_o <= bml_pkg::L1_BASE; // R14
               end
            end
            ST_FAIL: begin
               boot_fail_o <= 1'b1;
               serial_memory_select_out_n_o <= 1'b1;
            end
            default: st_q <= ST_FAIL;
         endcase
      end
   end

   // Holds the host off in slave mode, until run or fail, whenever no byte is being awaited.
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         host_hold_flag_o <= 1'b0;
      end else begin
         host_hold_flag_o <= hold_w; // R06
      end
   end

   assign rst_cfg_o = cfg_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i || sw_reset_i);

   AST_BYPASS_PC: assert property ((st_q == ST_DECIDE && !skip_w && // R01
      mode_w == bml_pkg::MODE_BYPASS) |=> ##1 (boot_done_o &&
      start_pc_o == bml_pkg::BYPASS_PC && ext_pack16_o))
      else $error("Bypass mode did not start external memory.");
   AST_AMC_SLOW: assert property ((boot_done_o && !mode_w[1]) |-> // R02
      (amc_hold_o == 4'h3 && amc_access_o == 4'hF && amc_setup_o == 4'h4))
      else $error("Async bus timing not at slowest default.");
   AST_FLASH_BANK0: assert property (mem_rd_o |-> // R03
      (!async_bank0_select_n_o && mode_w == bml_pkg::MODE_FLASH))
      else $error("Flash read without bank 0 select.");
   AST_HOLD_BUSY: assert property ((done_w && mode_w == bml_pkg::MODE_SPI_S) // R06
      |=> host_hold_flag_o)
      else $error("Host not held while a byte is processed.");
   AST_HOLD_SEL: assert property ((st_q == ST_HDR && done_w && // R07
      hdr_cnt_q == 4'h9) |=> (host_hold_sel_o == $past(hdr_nx_w[74:69])))
      else $error("Hold flag number not taken from flag bits.");
   AST_SCK_SEL: assert property ($changed(spi_sck_o) |-> // R08
      !serial_memory_select_out_n_o)
      else $error("Serial clock runs without memory select.");
   AST_CMD_FIRST: assert property ((st_q == ST_CMD && go_w) |=> // R09
      (spi_mosi_o == 1'b0 && sm_sh_q == 8'h03))
      else $error("Read command not loaded first.");
   AST_SAMPLE: assert property ((st_q == ST_SAMPLE && smp_q == 2'h2) |=> // R10
      (rst_cfg_o[1:0] == $past(pin2_q) && st_q == ST_DECIDE))
      else $error("Mode pins not sampled into configuration.");
   AST_DATA_WR: assert property ((st_q == ST_DATA && done_w) |=> // R11
      (l1_we_o && l1_data_o == $past(bval_w) && l1_addr_o == $past(dst_q)))
      else $error("Block byte not written to instruction memory.");
   AST_L1_START: assert property (($rose(boot_done_o) && !ext_pack16_o) |-> // R14
      (start_pc_o == 32'hFFA0_0000))
      else $error("Loaded code does not start at L1 base.");
   AST_SKIP: assert property ((st_q == ST_DECIDE && skip_w) |=> // R13
      (st_q == ST_RUN) ##1 (boot_done_o && !l1_we_o))
      else $error("Software skip did not jump to L1.");
   AST_CFG_HOLD: assert property ((st_q != ST_SAMPLE) |=> // R15
      $stable(rst_cfg_o[1:0]))
      else $error("Sampled boot mode changed without reset.");

endmodule

`default_nettype wire

// >>> bml_pkg.sv
// Purpose: Shared constants for the boot mode loader.
// Assumes: System clock of 40 MHz.
// Notes:   Header bytes arrive little-endian: target, count, flag word.
`default_nettype none

package bml_pkg;

   // ----------------------------------------------------------------
   // Boot modes and addresses
   // ----------------------------------------------------------------
   localparam logic [1:0]  MODE_BYPASS = 2'h0;
   localparam logic [1:0]  MODE_FLASH  = 2'h1;
   localparam logic [1:0]  MODE_SPI_S  = 2'h2;
   localparam logic [1:0]  MODE_SPI_M  = 2'h3;
   localparam logic [31:0] BYPASS_PC   = 32'h2000_0000;
   localparam logic [31:0] BANK0_BASE  = 32'h2000_0000;
   localparam logic [31:0] L1_BASE     = 32'hFFA0_0000;
   localparam logic [4:0]  CFG_RST     = 5'h00;
   localparam int          CFG_NOBOOT  = 4;

   // ----------------------------------------------------------------
   // Slowest asynchronous bus timing, in bus cycles
   // ----------------------------------------------------------------
   localparam logic [3:0]  AMC_HOLD    = 4'h3;
   localparam logic [3:0]  AMC_ACCESS  = 4'hF;
   localparam logic [3:0]  AMC_SETUP   = 4'h4;

   // ----------------------------------------------------------------
   // Block header layout
   // ----------------------------------------------------------------
   localparam logic [3:0]  HDR_LAST    = 4'h9;
   localparam int          FLAG_FINAL  = 15;
   localparam int          HOLD_LSB    = 5;
   localparam int          HOLD_MSB    = 10;

   // ----------------------------------------------------------------
   // Serial master and pin sampling
   // ----------------------------------------------------------------
   localparam logic [7:0]  SPI_RD_CMD  = 8'h03;
   localparam logic [7:0]  SPI_ADDR    = 8'h00;
   localparam logic [7:0]  SPI_BLANK   = 8'hFF;
   localparam logic [1:0]  SPI_MAXA    = 2'h3;
   localparam int          CLK_NS      = 25;
   localparam int          SPI_HALF_NS = 100;
   localparam int          HALF_CYC_I  = (SPI_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [2:0]  HALF_CYC    = 3'(HALF_CYC_I);
   localparam logic [1:0]  SMP_WAIT    = 2'h2;

endpackage

`default_nettype wire

// >>> bml_rx_if.sv
// Purpose: Carries received host bytes from the link domain.
// Assumes: Byte is stable whenever the toggle has changed.
// Notes:   Toggle flips once per complete byte.
`default_nettype none

interface bml_rx_if;
   logic [7:0] rx_byte;
   logic       rx_tgl;
   modport rx   (output rx_byte, output rx_tgl);
   modport core (input rx_byte, input rx_tgl);
endinterface

`default_nettype wire

// >>> bml_spi_rx.sv
// Purpose: Serial slave byte receiver on the host's clock.
// Assumes: Host shifts MSB first, data valid at rising clock edge.
// Notes:   Bit count is cleared by the select, as the clock stops.
`default_nettype none

module bml_spi_rx (
   input  wire logic link_sck_i,
   input  wire logic link_nrst_i,
   input  wire logic link_ss_n_i,
   input  wire logic link_mosi_i,
   bml_rx_if.rx      rx
);

   logic [2:0] bit_q;
   logic [6:0] sh_q;
   logic [7:0] byte_q;
   logic       tgl_q;

   // Shift in while selected; deselect restarts the byte.
   always_ff @(posedge link_sck_i or posedge link_ss_n_i) begin
      if (link_ss_n_i) begin
         bit_q <= 3'h0;
         sh_q  <= 7'h00;
      end else begin
         bit_q <= bit_q + 3'h1;
         sh_q  <= {sh_q[5:0], link_mosi_i};
      end
   end

   // Publish a whole byte and flip the toggle for the other domain.
   always_ff @(posedge link_sck_i or negedge link_nrst_i) begin
      if (!link_nrst_i) begin
         byte_q <= 8'h00;
         tgl_q  <= 1'b0;
      end else if (!link_ss_n_i && bit_q == 3'h7) begin
         byte_q <= {sh_q, link_mosi_i};
         tgl_q  <= ~tgl_q;
      end
   end

   assign rx.rx_byte = byte_q;
   assign rx.rx_tgl  = tgl_q;

   AST_RX_BYTE: assert property (@(posedge link_sck_i) disable iff (!link_nrst_i)
      (!link_ss_n_i && bit_q == 3'h7) |=> (byte_q[0] == $past(link_mosi_i))) // R05
      else $error("Received byte lost its last bit.");

endmodule

`default_nettype wire

// >>> bml_flash_model.sv
// Purpose: Parallel flash behind bank 0, serving the loader's byte reads.
// Assumes: A read request is held until it has been acknowledged.
// Notes:   While not answering, the data bus shows a pattern that changes every cycle.
`default_nettype none

module bml_flash_model (
   input  wire logic        clk_i,
   input  wire logic        rd_i,
   input  wire logic        sel_n_i,
   input  wire logic [31:0] addr_i,
   input  wire logic [2:0]  wait_i,
   output logic      [7:0]  data_o,
   output logic             ack_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] img [64];
   logic [2:0] cnt_q;

   // Start with an idle bus.
   initial begin
      data_o = 8'h00;
      ack_o = 1'b0;
      cnt_q = 3'h0;
   end

   // Answer a held read after wait_i cycles, and only while the chip enable is low.
   always @(posedge clk_i) begin
      ack_o <= 1'b0;
      data_o <= ~data_o;
      if (!rd_i || sel_n_i) begin
         cnt_q <= wait_i;
      end else if (!ack_o && cnt_q != 3'h0) begin
         cnt_q <= cnt_q - 3'h1;
      end else if (!ack_o) begin
         ack_o <= 1'b1;
         data_o <= img[addr_i[5:0]];
      end
   end
endmodule

`default_nettype wire

// >>> bml_boot_mode_loader_tb_top.sv
// Purpose: Self-checking bench for the boot mode loader.
// Assumes: Each boot finishes well inside the bounded waits.
// Notes:   Loaded bytes are compared against a queue of expected writes.
`default_nettype none

module bml_boot_mode_loader_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        ref_clk_i, nrst_i, sw_reset_i, skip_boot_i, boot_done_o, boot_fail_o;
   logic        ext_pack16_o, async_bank0_select_n_o, mem_rd_o, mem_ack_i, l1_we_o;
   logic        serial_memory_select_out_n_o, spi_sck_o, spi_mosi_o, spi_miso_i;
   logic        link_sck_i, link_ss_n_i, link_mosi_i, host_hold_flag_o, sel_seen;
   logic [1:0]  boot_select_pins_i;
   logic [2:0]  mwait;
   logic [3:0]  amc_hold_o, amc_access_o, amc_setup_o;
   logic [4:0]  rst_cfg_o;
   logic [5:0]  host_hold_sel_o;
   logic [7:0]  mem_data_i, l1_data_o, img_q[$];
   logic [31:0] start_pc_o, mem_addr_o, l1_addr_o, seed;
   logic [39:0] got, mo_q, exp_q[$];
   int          bad_count, compares, cyc;

   bml_boot_mode_loader dut (.ref_clk_i, .nrst_i, .sw_reset_i, .skip_boot_i,
      .boot_select_pins_i, .rst_cfg_o, .boot_done_o, .boot_fail_o, .start_pc_o,
      .ext_pack16_o, .amc_hold_o, .amc_access_o, .amc_setup_o, .async_bank0_select_n_o,
      .mem_rd_o, .mem_addr_o, .mem_data_i, .mem_ack_i, .l1_we_o, .l1_addr_o, .l1_data_o,
      .serial_memory_select_out_n_o, .spi_sck_o, .spi_mosi_o, .spi_miso_i, .link_sck_i,
      .link_ss_n_i, .link_mosi_i, .host_hold_flag_o, .host_hold_sel_o);

   bml_flash_model u_flash (.clk_i(ref_clk_i), .rd_i(mem_rd_o), .sel_n_i(async_bank0_select_n_o),
      .addr_i(mem_addr_o), .wait_i(mwait), .data_o(mem_data_i), .ack_o(mem_ack_i));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic close_out();
      if (bad_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Append one block to the image and note the writes it must cause.
   task automatic add_blk(input logic [31:0] tgt, input logic [31:0] cnt, input logic [15:0] flg);
      logic [79:0] h;
      h = {flg, cnt, tgt};
      for (int i = 0; i < 10; i++) img_q.push_back(h[8*i +: 8]);
      for (int i = 0; i < cnt; i++) begin
         seed = xs(seed);
         img_q.push_back(seed[7:0]);
         exp_q.push_back({tgt + 32'(i), seed[7:0]});
      end
   endtask

   // Reset by power-on or by a software pulse, with the strap pins set.
   task automatic boot(input logic [1:0] m, input logic pwr);
      boot_select_pins_i = m;
      if (pwr) begin
         nrst_i = 1'b0;
         repeat (20) @(posedge ref_clk_i);
      end else begin
         sw_reset_i = 1'b1;
         @(posedge ref_clk_i);
      end
      #2 nrst_i = 1'b1;
      sw_reset_i = 1'b0;
      repeat (6) @(posedge ref_clk_i);
      #2;
   endtask

   task automatic wait_end();
      for (int n = 0; n < 3000 && boot_done_o !== 1'b1 && boot_fail_o !== 1'b1; n++)
         @(posedge ref_clk_i);
      #2;
      if (boot_done_o !== 1'b1 && boot_fail_o !== 1'b1) begin
         bad_count++;
         close_out();
      end
   endtask

   // Host side of the slave link: one byte per frame, only while the hold flag is low.
   task automatic host_send(input logic [7:0] b);
      for (int n = 0; n < 500 && host_hold_flag_o !== 1'b0; n++) @(posedge ref_clk_i) #2;
      chk("hold low", {31'h0, host_hold_flag_o}, 32'h0);
      link_ss_n_i = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         link_mosi_i = b[i];
         #24 link_sck_i = 1'b1;
         #24 link_sck_i = 1'b0;
      end
      #24 link_ss_n_i = 1'b1;
      link_mosi_i = ~b[0];
      repeat (8) @(posedge ref_clk_i);
      #2;
   endtask

   // ----------------------------------------------------------------
   // Clock, timeout and output watcher
   // ----------------------------------------------------------------
   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end

   // Take the oldest noted write off the queue whenever the loader writes.
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         close_out();
      end
      if (serial_memory_select_out_n_o === 1'b0) sel_seen <= 1'b1;
      if (l1_we_o === 1'b1) begin
         if (exp_q.size() == 0) chk("l1 spare write", 32'h1, 32'h0);
         else begin
            got = exp_q.pop_front();
            chk("l1 addr", l1_addr_o, got[39:8]);
            chk("l1 data", {24'h0, l1_data_o}, {24'h0, got[7:0]});
         end
      end
   end

   // Record what the master shifts out at each rising serial clock.
   always @(posedge spi_sck_o) mo_q <= {mo_q[38:0], spi_mosi_o};

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      {nrst_i, sw_reset_i, skip_boot_i, sel_seen, link_sck_i} = 5'h00;
      {spi_miso_i, link_ss_n_i, link_mosi_i} = 3'h7;
      boot_select_pins_i = 2'h0;
      {bad_count, compares, cyc} = {32'h0, 32'h0, 32'h0};
      seed = 32'h2383_4c16;
      mwait = 3'h0;
      boot(bml_pkg::MODE_BYPASS, 1'b1);
      wait_end();
      chk("bypass pc", start_pc_o, bml_pkg::BYPASS_PC);
      chk("pack16", {31'h0, ext_pack16_o}, 32'h1);
      chk("amc", {20'h0, amc_hold_o, amc_access_o, amc_setup_o}, 32'h0000_03F4);
      chk("cfg", {27'h0, rst_cfg_o}, 32'h0);
      boot_select_pins_i = 2'h3;
      repeat (10) @(posedge ref_clk_i);
      #2;
      chk("cfg held", {27'h0, rst_cfg_o}, 32'h0);
      // Two flash blocks, the last one flagged, behind a randomly slow memory.
      add_blk(bml_pkg::L1_BASE + 32'h0000_0010, 32'h3, 16'h0000);
      add_blk(bml_pkg::L1_BASE, 32'h2, 16'h8000);
      foreach (img_q[i]) u_flash.img[i] = img_q[i];
      seed = xs(seed);
      mwait = seed[2:0];
      boot(bml_pkg::MODE_FLASH, 1'b0);
      wait_end();
      chk("flash cfg", {27'h0, rst_cfg_o}, 32'h1);
      chk("flash pc", start_pc_o, bml_pkg::L1_BASE);
      chk("flash left", exp_q.size(), 32'h0);
      chk("amc flash", {20'h0, amc_hold_o, amc_access_o, amc_setup_o}, 32'h0000_03F4);
      // Serial master with no device: the data line floats to its pull-up level.
      img_q.delete();
      boot(bml_pkg::MODE_SPI_M, 1'b0);
      wait_end();
      chk("no device", {31'h0, boot_fail_o}, 32'h1);
      chk("select used", {31'h0, sel_seen}, 32'h1);
      chk("spi out", mo_q[39:8], {bml_pkg::SPI_RD_CMD, 24'h00_0000});
      chk("spim cfg", {27'h0, rst_cfg_o}, 32'h3);
      // Serial slave fed by the host, hold flag number taken from the header.
      add_blk(bml_pkg::L1_BASE + 32'h0000_0020, 32'h1, 16'h82A0);
      boot(bml_pkg::MODE_SPI_S, 1'b1);
      foreach (img_q[i]) host_send(img_q[i]);
      wait_end();
      chk("hold sel", {26'h0, host_hold_sel_o}, 32'h15);
      chk("slave pc", start_pc_o, bml_pkg::L1_BASE);
      chk("slave left", exp_q.size(), 32'h0);
      // Software reset with the skip bit set loads nothing.
      skip_boot_i = 1'b1;
      boot(bml_pkg::MODE_FLASH, 1'b0);
      wait_end();
      chk("skip cfg", {27'h0, rst_cfg_o}, 32'h11);
      chk("skip done", {31'h0, boot_done_o}, 32'h1);
      chk("skip pc", start_pc_o, bml_pkg::L1_BASE);
      close_out();
   end
endmodule

`default_nettype wire
